// ==== core/hpm_cfg_if.sv ====
// configuration and readback carried between the register slave and the pin core
// assumes both ends run on core_clk
`timescale 1ns/100ps
`default_nettype none
interface hpm_cfg_if;
    logic [23:0] ctrl;
    logic [23:0] dir;
    logic [23:0] data;
    logic [3:0] gpioLevel;

    modport regs (output ctrl, output dir, output data, input gpioLevel);
    modport core (input ctrl, input dir, input data, output gpioLevel);
endinterface : hpm_cfg_if
`default_nettype wire

// ==== core/hpm_pin_mux.sv ====
// host port pin-function multiplexer: eight pins shared by pci and non-pci uses, pins 0..3 also by gpio
// assumes pins sampled synchronously to core_clk; pad logic outside resolves in/out/oe
//
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module hpm_pin_mux
    import hpm_pkg::*;
(
    input wire logic core_clk,  // device clock, 40 MHz
    input wire logic rst,  // synchronous reset, active high
    input wire logic [31:0] wb_adr_i,  // wishbone byte address
    input wire logic [31:0] wb_dat_i,  // wishbone write data
    input wire logic [3:0] wb_sel_i,  // wishbone byte enables
    input wire logic wb_we_i,  // wishbone write
    input wire logic wb_cyc_i,  // wishbone cycle
    input wire logic wb_stb_i,  // wishbone strobe
    output logic [31:0] wb_dat_o,  // wishbone read data
    output logic wb_ack_o,  // wishbone acknowledge
    input wire logic [7:0] pinIn,  // level seen on each multiplexed pin
    output logic [7:0] pinOut,  // value driven on each pin
    output logic [7:0] pinOe,  // high while the pin is driven
    input wire logic [7:0] pciOut,  // pci engine drive value per pin
    input wire logic [7:0] pciOe,  // pci engine drive enable per pin
    output logic [7:0] pciIn,  // pin level to the pci engine
    input wire logic [7:0] npOut,  // non-pci engine drive value per pin
    input wire logic [7:0] npOe,  // non-pci engine drive enable per pin
    output logic [7:0] npIn,  // pin level to the non-pci engine
    output logic [1:0] modeStatus  // current pin function, gpio/non-pci/pci
);
    hpm_cfg_if cfgBus ();

    hpm_wb_regs uRegs (
        .core_clk(core_clk),
        .rst(rst),
        .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i),
        .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .cfg(cfgBus)
    );

    hpm_mode_e mode;
    logic ackActiveLow;
    logic [7:0] pinOut_q;
    logic [7:0] pinOe_q;
    logic [7:0] pciIn_q;
    logic [7:0] npIn_q;
    logic [3:0] gpioLevel_q;
    logic [1:0] modeStatus_q;

    // the reserved mode code falls back to gpio, which keeps every pin an input after reset
    always_comb begin
        unique case (cfgBus.ctrl[MODE_LSB +: 2])
            MODE_PCI_CODE: mode = MODE_PCI;
            MODE_NONPCI_CODE: mode = MODE_NONPCI;
            default: mode = MODE_GPIO;
        endcase
    end

    assign ackActiveLow = cfgBus.ctrl[ACK_POL_BIT];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            modeStatus_q <= MODE_GPIO_CODE;
        end else begin
            unique case (mode)
                MODE_PCI: modeStatus_q <= MODE_PCI_CODE;
                MODE_NONPCI: modeStatus_q <= MODE_NONPCI_CODE;
                MODE_GPIO: modeStatus_q <= MODE_GPIO_CODE;
            endcase
        end
    end

    // gpio readback reflects the pad level whatever the direction
    always_ff @(posedge core_clk) begin
        if (rst) begin
            gpioLevel_q <= 4'h0;
        end else begin
            gpioLevel_q <= pinIn[GPIO_COUNT-1:0];
        end
    end

    // one cell per pin; the capability masks encode which use drives or listens on it
    for (genvar i = 0; i < PIN_COUNT; i++) begin : gPin
        localparam bit IS_GPIO = (i < GPIO_COUNT);
        localparam bit IS_ACK = (i == ACK_PIN);

        always_ff @(posedge core_clk) begin
            if (rst) begin
                pinOut_q[i] <= 1'b0;
                pinOe_q[i] <= 1'b0;
                pciIn_q[i] <= PCI_IDLE[i];
                npIn_q[i] <= NP_IDLE[i];
            end else begin
                pinOut_q[i] <= 1'b0;
                pinOe_q[i] <= 1'b0;
                pciIn_q[i] <= PCI_IDLE[i];
                npIn_q[i] <= NP_IDLE[i];
                unique case (mode)
                    MODE_PCI: begin
                        pinOut_q[i] <= pciOut[i];
                        pinOe_q[i] <= pciOe[i] & PCI_DRIVES[i];
                        if (PCI_RECEIVES[i]) begin
                            pciIn_q[i] <= pinIn[i];
                        end
                    end
                    MODE_NONPCI: begin
                        if (IS_ACK) begin
                            pinOut_q[i] <= npOut[i] ^ ackActiveLow;
                        end else begin
                            pinOut_q[i] <= npOut[i];
                        end
                        pinOe_q[i] <= npOe[i] & NP_DRIVES[i];
                        if (NP_RECEIVES[i]) begin
                            npIn_q[i] <= pinIn[i];
                        end
                    end
                    MODE_GPIO: begin
                        // pins 4..7 stay disconnected here
                        if (IS_GPIO) begin
                            pinOut_q[i] <= cfgBus.data[GPIO_LSB + i];
                            pinOe_q[i] <= cfgBus.dir[GPIO_LSB + i];
                        end
                    end
                endcase
            end
        end
    end

    assign cfgBus.gpioLevel = gpioLevel_q;
    assign pinOut = pinOut_q;
    assign pinOe = pinOe_q;
    assign pciIn = pciIn_q;
    assign npIn = npIn_q;
    assign modeStatus = modeStatus_q;

endmodule : hpm_pin_mux
`default_nettype wire

// ==== core/hpm_pkg.sv ====
// constants for the host port pin-function multiplexer
// assumes a 32-bit classic wishbone slave port and eight multiplexed pins
package hpm_pkg;

    localparam int unsigned PIN_COUNT = 8;
    localparam int unsigned GPIO_COUNT = 4;
    localparam int unsigned CTRL_WIDTH = 24;

    // register byte offsets
    localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
    localparam logic [31:0] DIR_OFS = 32'h0000_0004;
    localparam logic [31:0] DATA_OFS = 32'h0000_0008;
    localparam logic [31:0] LEVEL_OFS = 32'h0000_000C;

    // control register fields
    localparam int unsigned MODE_LSB = 0;
    localparam logic [1:0] MODE_GPIO_CODE = 2'h0;
    localparam logic [1:0] MODE_NONPCI_CODE = 2'h1;
    localparam logic [1:0] MODE_PCI_CODE = 2'h2;
    localparam int unsigned ACK_POL_BIT = 2;
    localparam logic [23:0] CTRL_RESET = 24'h00_0000;
    localparam logic [23:0] CTRL_MASK = 24'h00_0007;

    // direction and data registers hold port bits 20..23 at their own bit positions
    localparam int unsigned GPIO_LSB = 20;
    localparam logic [23:0] GPIO_MASK = 24'hF0_0000;
    localparam logic [23:0] DIR_RESET = 24'h00_0000;
    localparam logic [23:0] DATA_RESET = 24'h00_0000;

    // per-pin capabilities, bit i is multiplexed pin i
    localparam logic [7:0] PCI_DRIVES = 8'hB7;
    localparam logic [7:0] PCI_RECEIVES = 8'h7F;
    localparam logic [7:0] NP_DRIVES = 8'hE7;
    localparam logic [7:0] NP_RECEIVES = 8'h18;
    localparam logic [7:0] PCI_IDLE = 8'hFF;
    localparam logic [7:0] NP_IDLE = 8'hFF;
    localparam int unsigned ACK_PIN = 7;

    typedef enum logic [1:0] {
        MODE_GPIO,
        MODE_NONPCI,
        MODE_PCI
    } hpm_mode_e;

endpackage : hpm_pkg

// ==== core/hpm_wb_regs.sv ====
// classic wishbone register slave for the host port multiplexer
// assumes a master that holds each request until it sees ack
`timescale 1ns/100ps
`default_nettype none
module hpm_wb_regs
    import hpm_pkg::*;
(
    input wire logic core_clk,  // device clock
    input wire logic rst,  // synchronous reset, active high
    input wire logic [31:0] wb_adr_i,  // byte address
    input wire logic [31:0] wb_dat_i,  // write data
    input wire logic [3:0] wb_sel_i,  // byte enables
    input wire logic wb_we_i,  // write strobe
    input wire logic wb_cyc_i,  // cycle
    input wire logic wb_stb_i,  // strobe
    output logic [31:0] wb_dat_o,  // read data
    output logic wb_ack_o,  // acknowledge
    hpm_cfg_if.regs cfg  // configuration to the pin core
);
    logic [23:0] ctrl_q;
    logic [23:0] dir_q;
    logic [23:0] data_q;
    logic [31:0] rdata_q;
    logic ack_q;
    logic take;
    logic [23:0] laneMask;
    logic [23:0] wval;

    // one access per request; ack drops the cycle after it rose
    assign take = wb_cyc_i & wb_stb_i & ~ack_q;
    assign laneMask = {{8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wval = wb_dat_i[23:0];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= take;
        end
    end

    // writes land on the edge where the master samples ack; a cycle dropped early leaves the registers alone
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_q <= CTRL_RESET;
            dir_q <= DIR_RESET;
            data_q <= DATA_RESET;
        end else if (wb_cyc_i && wb_stb_i && ack_q && wb_we_i) begin
            unique case (wb_adr_i)
                CTRL_OFS: ctrl_q <= (ctrl_q & ~laneMask) | (wval & laneMask & CTRL_MASK);
                DIR_OFS: dir_q <= (dir_q & ~laneMask) | (wval & laneMask & GPIO_MASK);
                DATA_OFS: data_q <= (data_q & ~laneMask) | (wval & laneMask & GPIO_MASK);
                default: begin
                end
            endcase
        end
    end

    // unmapped addresses still answer, reading zero and ignoring writes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (take && !wb_we_i) begin
            unique case (wb_adr_i)
                CTRL_OFS: rdata_q <= {8'h00, ctrl_q};
                DIR_OFS: rdata_q <= {8'h00, dir_q};
                DATA_OFS: rdata_q <= {8'h00, data_q};
                LEVEL_OFS: rdata_q <= {8'h00, cfg.gpioLevel, 20'h0_0000};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign cfg.ctrl = ctrl_q;
    assign cfg.dir = dir_q;
    assign cfg.data = data_q;

endmodule : hpm_wb_regs
`default_nettype wire

// ==== tb/hpm_host_model.sv ====
// far-side host bus: resolves each shared pad from both drivers
// assumes pull-ups on every multiplexed line
`timescale 1ns/100ps
`default_nettype none
module hpm_host_model (
    input wire logic [7:0] pinOut,  // device drive
    input wire logic [7:0] pinOe,  // device enable
    input wire logic [7:0] hostOut,  // host drive
    input wire logic [7:0] hostOe,  // host enable
    output logic [7:0] pinIn  // pad level
);
    // contention is not modelled, the device wins
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pinIn[i] = pinOe[i] ? pinOut[i] : (hostOe[i] ? hostOut[i] : 1'b1);
        end
    end
endmodule : hpm_host_model
`default_nettype wire

// ==== tb/hpm_pin_mux_assertions.sv ====
// pin function checks at the multiplexer ports
// assumes engine inputs and pads are sampled on every core_clk edge
`timescale 1ns/100ps
`default_nettype none
module hpm_pin_mux_chk
    import hpm_pkg::*;
(
    input wire logic core_clk,  // clock
    input wire logic rst,  // reset
    input wire logic wb_cyc_i,  // cycle
    input wire logic wb_stb_i,  // strobe
    input wire logic wb_ack_o,  // ack
    input wire logic [7:0] pinIn,  // pad level
    input wire logic [7:0] pinOut,  // pad drive
    input wire logic [7:0] pinOe,  // pad enable
    input wire logic [7:0] pciOut,  // pci drive
    input wire logic [7:0] pciOe,  // pci enable
    input wire logic [7:0] pciIn,  // pci level
    input wire logic [7:0] npOut,  // np drive
    input wire logic [7:0] npOe,  // np enable
    input wire logic [7:0] npIn,  // np level
    input wire logic [1:0] modeStatus  // mode
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    pci_drive_a: assert property (modeStatus == MODE_PCI_CODE |-> pinOe == ($past(pciOe) & PCI_DRIVES)
        && ((pinOut ^ $past(pciOut)) & pinOe) == 8'h00) else $error("pci drive mismatch");
    np_drive_a: assert property (modeStatus == MODE_NONPCI_CODE |-> pinOe == ($past(npOe) & NP_DRIVES))
        else $error("non-pci enable mismatch");
    np_out_a: assert property (modeStatus == MODE_NONPCI_CODE |-> ((pinOut ^ $past(npOut)) & pinOe & 8'h7F) == 8'h00)
        else $error("non-pci drive mismatch");
    gpio_off_a: assert property (modeStatus == MODE_GPIO_CODE |-> pinOe[7:4] == 4'h0)
        else $error("disconnected pin driven");
    pci_in_a: assert property (modeStatus == MODE_PCI_CODE |-> pciIn == ($past(pinIn) | ~PCI_RECEIVES) && npIn == 8'hFF)
        else $error("pci input mismatch");
    np_in_a: assert property (modeStatus == MODE_NONPCI_CODE |-> npIn == ($past(pinIn) | ~NP_RECEIVES) && pciIn == 8'hFF)
        else $error("non-pci input mismatch");
    gpio_in_a: assert property (modeStatus == MODE_GPIO_CODE |-> pciIn == 8'hFF && npIn == 8'hFF)
        else $error("engine input not idle");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
endmodule : hpm_pin_mux_chk
bind hpm_pin_mux hpm_pin_mux_chk hpm_pin_mux_chk_i (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pciOut(pciOut),
    .pciOe(pciOe), .pciIn(pciIn), .npOut(npOut), .npOe(npOe), .npIn(npIn), .modeStatus(modeStatus));
`default_nettype wire

// ==== tb/hpm_pin_mux_tb.sv ====
// testbench for the pin multiplexer, all three pin functions
// assumes the host model resolves the pads
`timescale 1ns/100ps
`default_nettype none
module hpm_pin_mux_tb;
    import hpm_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] wbAdr = 32'h0, wbDatW = 32'h0, wbDatR, rd;
    logic wbWe = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbAck;
    logic [3:0] wbSel = 4'hF;
    logic [7:0] pinIn, pinOut, pinOe, pciIn, npIn;
    logic [7:0] pciOut = 8'h00, pciOe = 8'h00, npOut = 8'h00, npOe = 8'h00, hostOut = 8'h00, hostOe = 8'h00;
    logic [1:0] modeStatus;
    int badCount = 0;
    int checks = 0;
    hpm_pin_mux hpm_pin_mux_i (.core_clk(core_clk), .rst(rst), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_sel_i(wbSel),
        .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .pciOut(pciOut), .pciOe(pciOe), .pciIn(pciIn), .npOut(npOut), .npOe(npOe),
        .npIn(npIn), .modeStatus(modeStatus));
    hpm_host_model hpm_host_model_i (.pinOut(pinOut), .pinOe(pinOe), .hostOut(hostOut), .hostOe(hostOe), .pinIn(pinIn));
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            badCount++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] dat);
        @(posedge core_clk);
        {wbCyc, wbStb, wbWe, wbAdr, wbDatW} <= {2'h3, we, adr, dat};
        do @(posedge core_clk); while (wbAck !== 1'b1);
        rd = wbDatR;
        {wbCyc, wbStb, wbWe} <= 3'h0;
        @(posedge core_clk);
    endtask : wb
    task automatic drive(input logic [7:0] po, pd, no, nd, ho, hd);
        @(posedge core_clk);
        {pciOe, pciOut, npOe, npOut, hostOe, hostOut} <= {po, pd, no, nd, ho, hd};
    endtask : drive
    task automatic settle;
        repeat (3) @(posedge core_clk);
        #1;
    endtask : settle
    task automatic reset_check;
        chk(pinOe, 8'h00);
        chk({pciIn, npIn}, 16'hFFFF);
        wb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, CTRL_OFS, 32'hFFFF_FFFF);
        wb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, {8'h00, CTRL_MASK});
        chk(modeStatus, MODE_GPIO_CODE);
        // lane 0 disabled: the mode bits must survive a write of zero
        wbSel <= 4'hE;
        wb(1'b1, CTRL_OFS, 32'h0);
        wbSel <= 4'hF;
        wb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, {8'h00, CTRL_MASK});
        wb(1'b0, 32'h0000_0010, 32'h0);
        chk(rd, 32'h0);
    endtask : reset_check
    task automatic pci_check;
        // host holds the pure inputs low, so an input stuck at its idle level shows up
        drive(8'hFF, 8'hA5, 8'h00, 8'h00, 8'hFF, 8'h00);
        wb(1'b1, CTRL_OFS, {30'h0, MODE_PCI_CODE});
        settle();
        chk(modeStatus, MODE_PCI_CODE);
        chk(pinOe, PCI_DRIVES);
        chk(pinOut & PCI_DRIVES, 8'hA5 & PCI_DRIVES);
        chk({pciIn, npIn}, {(8'hA5 & PCI_DRIVES) | (8'h00 & ~PCI_DRIVES) | ~PCI_RECEIVES, 8'hFF});
    endtask : pci_check
    task automatic np_check;
        drive(8'h00, 8'h00, 8'hFF, 8'h81, 8'hFF, 8'h00);
        wb(1'b1, CTRL_OFS, {30'h0, MODE_NONPCI_CODE});
        settle();
        chk(modeStatus, MODE_NONPCI_CODE);
        chk(pinOe, NP_DRIVES);
        chk(pinOut & NP_DRIVES, 8'h81);
        chk({pciIn, npIn}, {8'hFF, 8'h81 | ~NP_RECEIVES});
        wb(1'b1, CTRL_OFS, {29'h0, 1'b1, MODE_NONPCI_CODE});
        settle();
        chk(pinOut[ACK_PIN], 1'b0);
    endtask : np_check
    task automatic gpio_check;
        drive(8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00);
        wb(1'b1, CTRL_OFS, {30'h0, MODE_GPIO_CODE});
        wb(1'b1, DIR_OFS, 32'h0050_0000);
        wb(1'b1, DATA_OFS, 32'h00F0_0000);
        wb(1'b1, LEVEL_OFS, 32'h00F0_0000);
        settle();
        chk(modeStatus, MODE_GPIO_CODE);
        chk(pinOe, 8'h05);
        chk(pinOut & 8'h05, 8'h05);
        chk({pciIn, npIn}, 16'hFFFF);
        wb(1'b0, LEVEL_OFS, 32'h0);
        chk(rd, 32'h0050_0000);
    endtask : gpio_check
    task automatic reset_mid_check;
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        chk({modeStatus, pinOe}, 10'h000);
        chk({pciIn, npIn}, 16'hFFFF);
        settle();
        chk(pinOe, 8'h00);
        wb(1'b0, DIR_OFS, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
    endtask : reset_mid_check
    task automatic conclude;
        $display("checks=%0d mismatches=%0d", checks, badCount);
        if (badCount == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        settle();
        reset_check();
        pci_check();
        np_check();
        gpio_check();
        reset_mid_check();
        conclude();
    end
    // roughly forty times the expected run
    initial begin
        #100000;
        badCount++;
        conclude();
    end
endmodule : hpm_pin_mux_tb
`default_nettype wire
